// ---- hw/pcs_chan_correct.sv ----
// offset and gain correction of one sampled channel
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defs.svh"

module pcs_chan_correct #(
  parameter int DATA_W = 16
) (
  input  wire logic [DATA_W-1:0] i_sample,
  input  wire logic [31:0]       i_coef,
  output logic      [DATA_W-1:0] o_result
);
  logic signed [DATA_W+1:0] sum;
  logic        [DATA_W:0]   clip;
  logic        [DATA_W+8:0] prod;
  logic        [DATA_W+8:0] scaled;

  // offset is signed 10 bits at [25:16], gain 8 bits at [7:0], 0x40 is unity
  always_comb begin
    sum    = $signed({2'b00, i_sample}) + (DATA_W+2)'($signed(i_coef[25:16]));
    clip   = sum[DATA_W+1] ? '0 : sum[DATA_W:0];   // negative clamps to black
    prod   = clip * i_coef[7:0];
    scaled = prod >> `PCS_GAIN_SHIFT;
    // saturate rather than wrap, so highlights stay white
    o_result = (|scaled[DATA_W+8:DATA_W]) ? '1 : scaled[DATA_W-1:0];
  end

endmodule
`default_nettype wire

// ---- hw/pcs_defs.svh ----
// offsets, field positions, codes and reset values of the pixel channel sequencer
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH

`define PCS_ADDR_W        8
`define PCS_ADDR_CFG      8'h00
`define PCS_ADDR_STATUS   8'h04
`define PCS_ADDR_COEF0    8'h10
`define PCS_COEF_COUNT    8
`define PCS_COEF_COLOR1   3

`define PCS_CFG_W         11
`define PCS_CFG_RST       11'h0f1
`define PCS_COEF_RST      32'h0000_0040
`define PCS_COEF_MASK     32'h03ff_00ff
`define PCS_GAIN_SHIFT    6

`define PCS_MODE_ORDER    2'b00
`define PCS_MODE_LINE     2'b01
`define PCS_MODE_TWO      2'b10
`define PCS_MODE_THREE    2'b11

`define PCS_PAIR_RG       2'b00
`define PCS_PAIR_GB       2'b01
`define PCS_PAIR_RB       2'b10

`define PCS_COLOR_RED     2'b00
`define PCS_COLOR_GREEN   2'b01
`define PCS_COLOR_BLUE    2'b10

`define PCS_LEN_MIN       3'b010
`define PCS_LEN_MAX       3'b101

`define PCS_RESP_OKAY     2'b00
`define PCS_RESP_SLVERR   2'b10

`endif

// ---- hw/pcs_pkg.sv ----
// types shared by the pixel channel sequencer files
package pcs_pkg;

  // converter input selected for one slot
  typedef enum logic [1:0] {
    PCS_CH_RED,
    PCS_CH_GREEN,
    PCS_CH_BLUE
  } pcs_chan_t;

  // sequencer state: waiting for the line sync after a restart, or running
  typedef enum logic {
    PCS_WAIT_SYNC,
    PCS_RUN
  } pcs_state_t;

  // configuration word, laid out as it sits in the config register
  typedef struct packed {
    logic [1:0] ratio;
    logic       aux;
    logic [1:0] mode;
    logic [1:0] color;
    logic       order;
    logic [2:0] len;
  } pcs_cfg_t;

  // one simultaneous sample of the three analog inputs
  typedef struct packed {
    logic [15:0] red;
    logic [15:0] green;
    logic [15:0] blue;
  } pcs_pix_t;

endpackage

// ---- hw/pcs_sequencer.sv ----
// pixel channel sequencer: sampling, converter multiplexing and register slave
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defs.svh"

module pcs_sequencer #(
  parameter int DATA_W = 16
) (
  input  wire logic                  i_clock,
  input  wire logic                  i_sys_rst,
  input  wire logic                  i_clk_en,
  // axi4-lite slave
  input  wire logic [7:0]            i_s_axi_awaddr,
  input  wire logic                  i_s_axi_awvalid,
  output logic                       o_s_axi_awready,
  input  wire logic [31:0]           i_s_axi_wdata,
  input  wire logic [3:0]            i_s_axi_wstrb,
  input  wire logic                  i_s_axi_wvalid,
  output logic                       o_s_axi_wready,
  output logic [1:0]                 o_s_axi_bresp,
  output logic                       o_s_axi_bvalid,
  input  wire logic                  i_s_axi_bready,
  input  wire logic [7:0]            i_s_axi_araddr,
  input  wire logic                  i_s_axi_arvalid,
  output logic                       o_s_axi_arready,
  output logic [31:0]                o_s_axi_rdata,
  output logic [1:0]                 o_s_axi_rresp,
  output logic                       o_s_axi_rvalid,
  input  wire logic                  i_s_axi_rready,
  // sensor side
  input  wire logic                  i_line_sync_pulse,
  input  wire logic                  i_input_pixel_clock,
  input  wire logic [DATA_W-1:0]     i_red_analog_input,
  input  wire logic [DATA_W-1:0]     i_green_analog_input,
  input  wire logic [DATA_W-1:0]     i_blue_analog_input,
  // converter side
  output logic                       o_conv_valid,
  output logic [DATA_W-1:0]          o_conv_data,
  output pcs_pkg::pcs_chan_t         o_conv_chan,
  output logic [2:0]                 o_color_index
);
  import pcs_pkg::*;

  logic [`PCS_CFG_W-1:0] cfg_word_ff;
  logic [31:0]           coef_ff [0:`PCS_COEF_COUNT-1];
  pcs_cfg_t              cfg;
  pcs_state_t            state_ff;
  pcs_state_t            nxt_state;
  pcs_pix_t              pix_ff;
  logic [1:0]            seq_ff;
  logic [1:0]            nxt_seq;
  logic [1:0]            burst_ff;
  logic [2:0]            color_ff;
  logic [2:0]            nxt_color;
  logic                  conv_valid_ff;
  logic [DATA_W-1:0]     conv_data_ff;
  pcs_chan_t             conv_chan_ff;

  logic                  aw_hold_ff;
  logic [7:0]            awaddr_ff;
  logic                  w_hold_ff;
  logic [31:0]           wdata_ff;
  logic [3:0]            wstrb_ff;
  logic                  bvalid_ff;
  logic [1:0]            bresp_ff;
  logic                  rvalid_ff;
  logic [31:0]           rdata_ff;
  logic [1:0]            rresp_ff;

  logic                  do_write;
  logic                  wr_cfg;
  logic                  wr_hit;
  logic [31:0]           wmask;
  logic [31:0]           cfg_merged;
  logic                  coef_hit;
  logic [2:0]            coef_idx;
  logic                  rd_coef_hit;
  logic [2:0]            rd_coef_idx;
  logic [31:0]           rd_word;
  logic                  rd_hit;

  logic [1:0]            n_slots;
  logic [1:0]            burst_len;
  logic                  red_multi;
  logic [2:0]            line_len;
  logic                  emit;
  pcs_chan_t             slot_chan;
  pcs_chan_t             pair_first;
  pcs_chan_t             pair_second;
  logic [DATA_W-1:0]     samp   [0:2];
  logic [31:0]           ch_coef[0:2];
  logic [DATA_W-1:0]     corr   [0:2];

  // configuration fields decoded straight from the stored word
  assign cfg = pcs_cfg_t'(cfg_word_ff);

  // ---------------- axi4-lite write channel ----------------

  // address and data are taken independently; the write fires once both are held
  assign o_s_axi_awready = !aw_hold_ff;
  assign o_s_axi_wready  = !w_hold_ff;
  assign do_write        = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign coef_idx = 3'((awaddr_ff - `PCS_ADDR_COEF0) >> 2);
  assign coef_hit = (awaddr_ff[1:0] == 2'b00) && (awaddr_ff >= `PCS_ADDR_COEF0)
                    && (awaddr_ff < `PCS_ADDR_COEF0 + 8'(4 * `PCS_COEF_COUNT));
  // status is read-only, so a write to it is refused like an unmapped one
  assign wr_hit   = (awaddr_ff == `PCS_ADDR_CFG) || coef_hit;
  assign wr_cfg   = do_write && (awaddr_ff == `PCS_ADDR_CFG) && (|wstrb_ff[1:0]);
  assign cfg_merged = ({21'h0, cfg_word_ff} & ~wmask) | (wdata_ff & wmask);

  // write address and data holding registers
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      aw_hold_ff <= 1'b0;
      awaddr_ff  <= 8'h00;
      w_hold_ff  <= 1'b0;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end else if (i_clk_en) begin
      if (i_s_axi_awvalid && !aw_hold_ff) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff  <= i_s_axi_awaddr;
      end else if (do_write) begin
        aw_hold_ff <= 1'b0;
      end
      if (i_s_axi_wvalid && !w_hold_ff) begin
        w_hold_ff <= 1'b1;
        wdata_ff  <= i_s_axi_wdata;
        wstrb_ff  <= i_s_axi_wstrb;
      end else if (do_write) begin
        w_hold_ff <= 1'b0;
      end
    end
  end

  // write response: slave error on an unmapped or read-only address
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `PCS_RESP_OKAY;
    end else if (i_clk_en) begin
      if (do_write) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_hit ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
      end else if (i_s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // config register; only byte lanes 0 and 1 carry bits
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      cfg_word_ff <= `PCS_CFG_RST;
    end else if (i_clk_en && wr_cfg) begin
      cfg_word_ff <= cfg_merged[`PCS_CFG_W-1:0];
    end
  end

  // coefficient bank: red, green, blue, then red colours 1 to 5
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      for (int k = 0; k < `PCS_COEF_COUNT; k++) begin
        coef_ff[k] <= `PCS_COEF_RST;
      end
    end else if (i_clk_en && do_write && coef_hit) begin
      coef_ff[coef_idx] <= ((coef_ff[coef_idx] & ~wmask) | (wdata_ff & wmask))
                           & `PCS_COEF_MASK;
    end
  end

  // ---------------- axi4-lite read channel ----------------

  assign o_s_axi_arready = !rvalid_ff;
  assign rd_coef_idx = 3'((i_s_axi_araddr - `PCS_ADDR_COEF0) >> 2);
  assign rd_coef_hit = (i_s_axi_araddr[1:0] == 2'b00)
                       && (i_s_axi_araddr >= `PCS_ADDR_COEF0)
                       && (i_s_axi_araddr < `PCS_ADDR_COEF0 + 8'(4 * `PCS_COEF_COUNT));

  // read decode; status shows the live sequencer position
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (i_s_axi_araddr == `PCS_ADDR_CFG) begin
      rd_word = {21'h0, cfg_word_ff};
    end else if (i_s_axi_araddr == `PCS_ADDR_STATUS) begin
      rd_word = {22'h0, burst_ff, 1'b0, color_ff, 1'b0, seq_ff, state_ff == PCS_WAIT_SYNC};
    end else if (rd_coef_hit) begin
      rd_word = coef_ff[rd_coef_idx];
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `PCS_RESP_OKAY;
    end else if (i_clk_en) begin
      if (i_s_axi_arvalid && !rvalid_ff) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_word;
        rresp_ff  <= rd_hit ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
      end else if (i_s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign o_s_axi_bvalid = bvalid_ff;
  assign o_s_axi_bresp  = bresp_ff;
  assign o_s_axi_rvalid = rvalid_ff;
  assign o_s_axi_rdata  = rdata_ff;
  assign o_s_axi_rresp  = rresp_ff;

  // ---------------- sequencing ----------------

  // slots per pixel follow the internal clock ratio: code 0 1x, 1 2x, 2 3x
  always_comb begin
    case (cfg.ratio)
      2'd1:    burst_len = 2'd2;
      2'd2:    burst_len = 2'd3;
      default: burst_len = 2'd1;
    endcase
    case (cfg.mode)
      `PCS_MODE_THREE: n_slots = 2'd3;
      `PCS_MODE_TWO:   n_slots = 2'd2;
      default:         n_slots = 2'd1;
    endcase
  end

  // red multi-colour line mode needs aux 0; other lengths behave as mono
  assign red_multi = (cfg.mode == `PCS_MODE_LINE) && (cfg.color == `PCS_COLOR_RED)
                     && !cfg.aux;
  assign line_len  = (red_multi && cfg.len >= `PCS_LEN_MIN && cfg.len <= `PCS_LEN_MAX)
                     ? cfg.len : 3'd1;

  // two-input pair: first listed input converts first when order is 0
  always_comb begin
    case (cfg.color)
      `PCS_PAIR_RG: begin
        pair_first  = PCS_CH_RED;
        pair_second = PCS_CH_GREEN;
      end
      `PCS_PAIR_RB: begin
        pair_first  = PCS_CH_RED;
        pair_second = PCS_CH_BLUE;
      end
      default: begin  // green first, blue second
        pair_first  = PCS_CH_GREEN;
        pair_second = PCS_CH_BLUE;
      end
    endcase
  end

  // channel owning the current slot
  always_comb begin
    case (cfg.mode)
      `PCS_MODE_THREE: begin
        case (seq_ff)
          2'd0:    slot_chan = cfg.order ? PCS_CH_BLUE : PCS_CH_RED;
          2'd1:    slot_chan = PCS_CH_GREEN;
          default: slot_chan = cfg.order ? PCS_CH_RED : PCS_CH_BLUE;
        endcase
      end
      `PCS_MODE_TWO: begin
        slot_chan = (seq_ff[0] ^ cfg.order) ? pair_second : pair_first;
      end
      default: begin
        case (cfg.color)
          `PCS_COLOR_GREEN: slot_chan = PCS_CH_GREEN;
          `PCS_COLOR_BLUE:  slot_chan = PCS_CH_BLUE;
          default:          slot_chan = PCS_CH_RED;
        endcase
      end
    endcase
  end

  // restart state: a config write wins over a line sync in the same cycle
  always_comb begin
    nxt_state = state_ff;
    if (wr_cfg) begin
      nxt_state = PCS_WAIT_SYNC;
    end else if (i_line_sync_pulse) begin
      nxt_state = PCS_RUN;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_ff <= PCS_WAIT_SYNC;
    end else if (i_clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // the per-channel order mode is handled elsewhere, so it emits nothing here
  assign emit = (state_ff == PCS_RUN) && (cfg.mode != `PCS_MODE_ORDER)
                && (burst_ff != 2'd0) && !i_line_sync_pulse && !wr_cfg;

  // all inputs captured on the same pixel edge
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      pix_ff <= '0;
    end else if (i_clk_en && i_input_pixel_clock) begin
      pix_ff <= '{red: i_red_analog_input, green: i_green_analog_input,
                  blue: i_blue_analog_input};
    end
  end

  // slot burst: a new pixel reloads it, a line sync cancels what is left
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      burst_ff <= 2'd0;
    end else if (i_clk_en) begin
      if (i_input_pixel_clock && nxt_state == PCS_RUN) begin
        burst_ff <= burst_len;
      end else if (i_line_sync_pulse || wr_cfg) begin
        burst_ff <= 2'd0;
      end else if (emit) begin
        burst_ff <= burst_ff - 2'd1;
      end
    end
  end

  // slot position wraps per pixel group and snaps to zero on line sync
  always_comb begin
    nxt_seq = seq_ff;
    if (i_line_sync_pulse || wr_cfg) begin
      nxt_seq = 2'd0;
    end else if (emit) begin
      nxt_seq = (seq_ff + 2'd1 >= n_slots) ? 2'd0 : seq_ff + 2'd1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      seq_ff <= 2'd0;
    end else if (i_clk_en) begin
      seq_ff <= nxt_seq;
    end
  end

  // colour line index: first colour after restart, else step with wrap
  always_comb begin
    nxt_color = color_ff;
    if (i_line_sync_pulse && !wr_cfg) begin
      if (state_ff == PCS_WAIT_SYNC || color_ff >= line_len) begin
        nxt_color = cfg.order ? line_len - 3'd1 : 3'd0;
      end else if (cfg.order) begin
        nxt_color = (color_ff == 3'd0) ? line_len - 3'd1 : color_ff - 3'd1;
      end else begin
        nxt_color = (color_ff + 3'd1 >= line_len) ? 3'd0 : color_ff + 3'd1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      color_ff <= 3'd0;
    end else if (i_clk_en) begin
      color_ff <= nxt_color;
    end
  end

  // ---------------- correction and output ----------------

  assign samp[0] = pix_ff.red;
  assign samp[1] = pix_ff.green;
  assign samp[2] = pix_ff.blue;

  // red swaps to the current colour's coefficient set in multi-colour line mode
  assign ch_coef[0] = red_multi ? coef_ff[`PCS_COEF_COLOR1 + 32'(color_ff)] : coef_ff[0];
  assign ch_coef[1] = coef_ff[1];
  assign ch_coef[2] = coef_ff[2];

  // one corrector per channel, all running in parallel
  for (genvar g = 0; g < 3; g++) begin : g_chan
    pcs_chan_correct #(
      .DATA_W   (DATA_W)
    ) u_correct (
      .i_sample (samp[g]),
      .i_coef   (ch_coef[g]),
      .o_result (corr[g])
    );
  end

  // converter output word, registered
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      conv_valid_ff <= 1'b0;
      conv_data_ff  <= '0;
      conv_chan_ff  <= PCS_CH_RED;
    end else if (i_clk_en) begin
      conv_valid_ff <= emit;
      if (emit) begin
        conv_data_ff <= corr[slot_chan];
        conv_chan_ff <= slot_chan;
      end
    end
  end

  assign o_conv_valid  = conv_valid_ff;
  assign o_conv_data   = conv_data_ff;
  assign o_conv_chan   = conv_chan_ff;
  assign o_color_index = color_ff;

endmodule
`default_nettype wire

// ---- sim/pcs_sensor_model.sv ----
// behavioural sensor front: line sync, pixel strobe and three sampled inputs
`timescale 1ns/1ps
`default_nettype none
module pcs_sensor_model (
  input  wire logic        i_clock,
  output logic             o_line_sync_pulse,
  output logic             o_input_pixel_clock,
  output pcs_pkg::pcs_pix_t o_pix
);
  import pcs_pkg::*;
  initial {o_line_sync_pulse, o_input_pixel_clock, o_pix} = '0;
  // one-cycle line sync, then a quiet cycle so no strobe shares its edge
  task automatic line();
    @(posedge i_clock) o_line_sync_pulse <= 1'b1;
    @(posedge i_clock) o_line_sync_pulse <= 1'b0;
    @(posedge i_clock);
  endtask
  // inputs are good for the strobe cycle only and inverted after it, so a late
  // capture shows; strobes five cycles apart clear the longest burst
  task automatic pixel(input logic [15:0] p);
    @(posedge i_clock) o_input_pixel_clock <= 1'b1;
    o_pix <= {16'h1000 + p, 16'h2000 + p, 16'h3000 + p};
    @(posedge i_clock) o_input_pixel_clock <= 1'b0;
    o_pix <= ~o_pix;
    repeat (3) @(posedge i_clock);
  endtask
endmodule
`default_nettype wire

// ---- sim/pcs_sequencer_properties.sv ----
// port-level checks of the pixel channel sequencer
`timescale 1ns/1ps
`default_nettype none
module pcs_chk (
  input wire logic               i_clock,
  input wire logic               i_sys_rst,
  input wire logic               i_s_axi_awvalid,
  input wire logic               o_s_axi_awready,
  input wire logic               o_s_axi_wready,
  input wire logic               o_s_axi_bvalid,
  input wire logic [1:0]         o_s_axi_bresp,
  input wire logic               i_s_axi_arvalid,
  input wire logic               o_s_axi_arready,
  input wire logic               o_s_axi_rvalid,
  input wire logic               i_line_sync_pulse,
  input wire logic               i_input_pixel_clock,
  input wire logic               o_conv_valid,
  input var  pcs_pkg::pcs_chan_t o_conv_chan,
  input wire logic [2:0]         o_color_index
);
  import pcs_pkg::*;
  logic sync_seen_ff;
  // any write may restart the sequencer, so the sync is forgotten until the next one
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || i_s_axi_awvalid) sync_seen_ff <= 1'b0;
    else if (i_line_sync_pulse) sync_seen_ff <= 1'b1;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  AST_SYNC_CANCEL: assert property (i_line_sync_pulse |=> !o_conv_valid)
    else $error("slot output right after line sync");
  AST_TICK_SLOT: assert property (
    sync_seen_ff && i_input_pixel_clock && !i_s_axi_awvalid |-> ##2 o_conv_valid)
    else $error("pixel strobe gave no slot two cycles later");
  AST_BURST_MAX: assert property (o_conv_valid [*3] |=> !o_conv_valid)
    else $error("more than three slots in a row");
  AST_CHAN_STEP: assert property (
    o_conv_valid && $past(o_conv_valid) |-> o_conv_chan != $past(o_conv_chan))
    else $error("back to back slots repeat a channel");
  AST_COLOR_SYNC: assert property ($changed(o_color_index) |-> $past(i_line_sync_pulse))
    else $error("colour index moved without line sync");
  AST_COLOR_RANGE: assert property (o_color_index <= 3'h4)
    else $error("colour index beyond five colours");
  // readies reopen as the write lands, so only the rising response is tied to both holds
  AST_B_HOLD: assert property ($rose(o_s_axi_bvalid) |->
    $past(!o_s_axi_awready && !o_s_axi_wready))
    else $error("write answered before address and data were both held");
  AST_AR_ANSWER: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read taken without data next cycle");
  cover property (o_conv_valid && o_conv_chan == PCS_CH_BLUE);
  cover property (o_color_index == 3'h4);
  cover property (o_s_axi_bvalid && o_s_axi_bresp[1]);
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking bench for the pixel channel sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import pcs_pkg::*;
  logic        i_clock, i_sys_rst, i_clk_en, i_line_sync_pulse, i_input_pixel_clock;
  logic        i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid;
  logic        i_s_axi_rready, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
  logic        o_s_axi_arready, o_s_axi_rvalid, o_conv_valid;
  logic [7:0]  i_s_axi_awaddr, i_s_axi_araddr;
  logic [31:0] i_s_axi_wdata, o_s_axi_rdata, rdv;
  logic [3:0]  i_s_axi_wstrb;
  logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, rsp;
  logic [15:0] i_red_analog_input, i_green_analog_input, i_blue_analog_input, o_conv_data;
  logic [2:0]  o_color_index;
  pcs_chan_t   o_conv_chan;
  int          n_fail = 0;
  int          comparisons = 0;
  logic [17:0] q[$], eq[$];
  pcs_sequencer uut (.*);
  pcs_sensor_model sm (.i_clock(i_clock), .o_line_sync_pulse(i_line_sync_pulse),
    .o_input_pixel_clock(i_input_pixel_clock),
    .o_pix({i_red_analog_input, i_green_analog_input, i_blue_analog_input}));
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  // every converter slot is logged as channel and data
  always @(posedge i_clock) if (o_conv_valid === 1'b1) q.push_back({o_conv_chan, o_conv_data});
  // unity red, doubled green, blue lifted by 16, as set up in t_regs
  function automatic logic [17:0] ev(pcs_chan_t c, int k);
    logic [15:0] v;
    v = {2'h0, c + 2'h1, 12'h000} + 16'(k);
    return {c, c == PCS_CH_GREEN ? v << 1 : c == PCS_CH_BLUE ? v + 16'h0010 : v};
  endfunction
  // one write or read; each channel is released at the edge that takes it
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic [1:0] r);
    @(posedge i_clock);
    if (w) begin
      {i_s_axi_awaddr, i_s_axi_wdata} <= {a, wd};
      {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= 3'h7;
    end else {i_s_axi_araddr, i_s_axi_arvalid, i_s_axi_rready} <= {a, 2'h3};
    for (int i = 0; i < 40; i++) begin
      @(posedge i_clock);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
      if (o_s_axi_bvalid || o_s_axi_rvalid) begin
        {i_s_axi_bready, i_s_axi_rready} <= 2'h0;
        rd = o_s_axi_rdata;
        r = w ? o_s_axi_bresp : o_s_axi_rresp;
        break;
      end
      // a transfer that never answers counts, instead of running on silently
      if (i == 39) `CHK("bus answer", 1'b1, o_s_axi_bvalid | o_s_axi_rvalid)
    end
  endtask
  task automatic wcfg(input logic [31:0] v);
    bus(1'b1, `PCS_ADDR_CFG, v, rdv, rsp);
  endtask
  // one line of npix pixels; n slots each, slot s takes channel seq[s % m]
  task automatic run_pix(input int npix, input int n, input int m,
                         input pcs_chan_t c0, input pcs_chan_t c1, input pcs_chan_t c2);
    pcs_chan_t s[3];
    s = '{c0, c1, c2};
    q.delete();
    eq.delete();
    sm.line();
    for (int k = 0; k < npix; k++) begin
      sm.pixel(16'(k));
      for (int j = 0; j < n; j++) eq.push_back(ev(s[(k * n + j) % m], k));
    end
    repeat (2) @(posedge i_clock);
    `CHK("slot count", eq.size(), q.size())
    foreach (eq[i]) `CHK("slot", eq[i], q[i])
  endtask
  task automatic t_regs();
    bus(1'b0, `PCS_ADDR_CFG, 32'h0, rdv, rsp);
    `CHK("cfg reset", 32'(`PCS_CFG_RST), rdv)
    bus(1'b0, 8'h14, 32'h0, rdv, rsp);
    `CHK("coef reset", `PCS_COEF_RST, rdv)
    bus(1'b0, 8'h80, 32'h0, rdv, rsp);
    `CHK("unmapped read", `PCS_RESP_SLVERR, rsp)
    bus(1'b1, `PCS_ADDR_STATUS, 32'h0, rdv, rsp);
    `CHK("status write", `PCS_RESP_SLVERR, rsp)
    bus(1'b1, 8'h14, 32'h0000_0080, rdv, rsp);
    bus(1'b1, 8'h18, 32'h0010_0040, rdv, rsp);
    bus(1'b0, 8'h18, 32'h0, rdv, rsp);
    `CHK("blue coef", 32'h0010_0040, rdv)
  endtask
  // three inputs: 3x both orders, then 1x where a new line realigns the slots
  task automatic t_three();
    wcfg(32'h0000_04f1);
    run_pix(2, 3, 3, PCS_CH_RED, PCS_CH_GREEN, PCS_CH_BLUE);
    wcfg(32'h0000_04f9);
    run_pix(2, 3, 3, PCS_CH_BLUE, PCS_CH_GREEN, PCS_CH_RED);
    wcfg(32'h0000_00f1);
    run_pix(2, 1, 3, PCS_CH_RED, PCS_CH_GREEN, PCS_CH_BLUE);
    run_pix(2, 1, 3, PCS_CH_RED, PCS_CH_GREEN, PCS_CH_BLUE);
  endtask
  // two inputs: every pair and order at 2x, then the default pair at 1x
  task automatic t_two();
    pcs_chan_t a[3];
    pcs_chan_t b[3];
    a = '{PCS_CH_RED, PCS_CH_GREEN, PCS_CH_RED};
    b = '{PCS_CH_GREEN, PCS_CH_BLUE, PCS_CH_BLUE};
    for (int c = 0; c < 3; c++) begin
      for (int o = 0; o < 2; o++) begin
        wcfg(32'h0000_0281 | 32'(c << 4) | 32'(o << 3));
        if (o == 0) run_pix(2, 2, 2, a[c], b[c], a[c]);
        else run_pix(2, 2, 2, b[c], a[c], b[c]);
      end
    end
    wcfg(32'h0000_0091);
    run_pix(2, 1, 2, PCS_CH_GREEN, PCS_CH_BLUE, PCS_CH_GREEN);
  endtask
  // colour lines: each length both ways; a write restarts from the first colour
  task automatic t_line();
    logic [2:0] e;
    for (int n = 2; n < 6; n++) begin
      for (int o = 0; o < 2; o++) begin
        wcfg(32'h0000_0040 | 32'(o << 3) | 32'(n));
        for (int k = 0; k < n + 2; k++) begin
          sm.line();
          e = 3'((o == 1) ? n - 1 - k % n : k % n);
          `CHK("colour index", e, o_color_index)
        end
      end
    end
    wcfg(32'h0000_0143);
    sm.line();
    sm.line();
    `CHK("aux colour index", 3'h0, o_color_index)
    // red colour 2 gets double gain, so the second line's pixel shows the swap
    bus(1'b1, 8'h20, 32'h0000_0080, rdv, rsp);
    wcfg(32'h0000_0042);
    run_pix(1, 1, 1, PCS_CH_RED, PCS_CH_RED, PCS_CH_RED);
    sm.line();
    sm.pixel(16'h0000);
    repeat (2) @(posedge i_clock);
    `CHK("colour 2 data", 16'h2000, o_conv_data)
    `CHK("colour 2 index", 3'h1, o_color_index)
  endtask
  task automatic close_out();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // the sequence needs a few hundred cycles; a hang stops here
  initial begin
    repeat (40000) @(posedge i_clock);
    n_fail++;
    close_out();
  end
  initial begin
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready} = '0;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = '0;
    i_s_axi_wstrb = 4'hf;
    i_clk_en = 1'b1;
    i_sys_rst = 1'b1;
    repeat (16) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    t_regs();
    t_three();
    t_two();
    t_line();
    close_out();
  end
endmodule
bind pcs_sequencer pcs_chk u_chk (.*);
`default_nettype wire
